// ===== design/dds_pkg.sv
// Shared constants and types for the tuning-word loader and sine synthesizer.
package dds_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths of the datapath.
  localparam int TUNE_W = 32;   // Width of the tuning word and phase.
  localparam int PHASE_IN_W = 15;   // Phase bits used by the sine converter.
  localparam int SAMPLE_W = 12;   // Width of one output sample.
  localparam int QTR_W = 13;   // Phase bits within one quarter cycle.
  localparam int TBL_IDX_W = 6;   // Coarse table index bits.
  localparam int FRAC_W = 7;   // Interpolation fraction bits.
  localparam int MAG_W = 11;   // Magnitude bits of a quarter-wave value.

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and fixed codes.
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;  // Frequency register after reset.
  localparam logic [31:0] PHASE_RST = 32'h0000_0000;  // Phase after reset or clear.
  localparam logic [11:0] SAMPLE_MID = 12'h800;  // Offset-binary midscale.
  localparam int SYNC_STAGES = 2;   // Flip-flops in each pin synchroniser.

  ////////////////////////////////////////////////////////////////////////////
  // Timing of the host's buffer clock and transfer strobe.
  localparam int CLK_PERIOD_NS = 8;   // System clock period.
  localparam int BCLK_HIGH_MIN_NS = 10;  // Least high and low time of the buffer clock.
  localparam int BCLK_HALF_CYC = (BCLK_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XFER_HOLD_CYC = 4;   // Cycles in the transfer state; the strobe stays high for three.
  localparam int SERIAL_BITS = 32;  // Buffer clocks in one serial load.

  ////////////////////////////////////////////////////////////////////////////
  // Host command-port register offsets and fields.
  localparam logic [3:0] REG_TUNE = 4'h0;   // Tuning word to send.
  localparam logic [3:0] REG_CTRL = 4'h4;   // Bit 0: parallel load when set.
  localparam logic [3:0] REG_CMD = 4'h8;   // Write bit 0 to start a load.
  localparam logic [3:0] REG_STAT = 4'hC;   // Bit 0 busy, bit 1 done.
  localparam int CTRL_PAR_BIT = 0;
  localparam int CMD_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-wave table: 2047 * sin(k * 90deg / 64) for k = 0 .. 64.
  localparam logic [11:0] QTR_TBL [0:64] = '{
    12'h000, 12'h032, 12'h064, 12'h097, 12'h0C9, 12'h0FB, 12'h12C, 12'h15E,
    12'h18F, 12'h1C0, 12'h1F1, 12'h222, 12'h252, 12'h282, 12'h2B2, 12'h2E1,
    12'h30F, 12'h33E, 12'h36B, 12'h398, 12'h3C5, 12'h3F1, 12'h41C, 12'h447,
    12'h471, 12'h49B, 12'h4C3, 12'h4EB, 12'h513, 12'h539, 12'h55F, 12'h583,
    12'h5A7, 12'h5CB, 12'h5ED, 12'h60E, 12'h62E, 12'h64E, 12'h66C, 12'h68A,
    12'h6A6, 12'h6C1, 12'h6DC, 12'h6F5, 12'h70D, 12'h724, 12'h73A, 12'h74F,
    12'h763, 12'h776, 12'h787, 12'h798, 12'h7A7, 12'h7B5, 12'h7C2, 12'h7CD,
    12'h7D8, 12'h7E1, 12'h7E9, 12'h7F0, 12'h7F5, 12'h7F9, 12'h7FD, 12'h7FE,
    12'h7FF
  };

  // States of the host loader.
  typedef enum logic [2:0] {
    DDS_IDLE,
    DDS_SHIFT,
    DDS_XFER
  } dds_host_state_t;

endpackage

// ===== design/dds_link_if.sv
// Pin-level link between the host loader and the synthesizer.
`timescale 1ns/1ps
interface dds_link_if;

  // Buffer clock made by the host; rising edges load the buffer.
  logic buffer_load_clock;
  // High while a buffer clock edge should load the buffer.
  logic buffer_load_enable;
  // High selects a parallel load, low a serial shift.
  logic load_mode_parallel;
  // Parallel tuning word; bit 0 doubles as the serial pin.
  logic [31:0] tune_word;
  // Asks the synthesizer to copy the buffer into the frequency register.
  logic freq_word_transfer_strobe;

  // The host drives every link signal.
  modport host (
    output buffer_load_clock,
    output buffer_load_enable,
    output load_mode_parallel,
    output tune_word,
    output freq_word_transfer_strobe
  );

  // The synthesizer only listens.
  modport device (
    input buffer_load_clock,
    input buffer_load_enable,
    input load_mode_parallel,
    input tune_word,
    input freq_word_transfer_strobe
  );

endinterface

// ===== design/dds_device.sv
// Synthesizer end: tuning buffer, frequency register, accumulator and sine output.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dds_device
  import dds_pkg::*;
#(
  parameter int TW = TUNE_W
) (
  // System clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Link from the host loader.
  dds_link_if.device LINK,
  // Accumulator and output-format controls from board pins.
  input wire logic PHASE_CLEAR,
  input wire logic OUTPUT_FORMAT_SELECT,
  input wire logic CARRY_TOGGLE_ENABLE,
  input wire logic ACCUMULATOR_CARRY_IN,
  // Sample output toward the converter.
  output logic [SAMPLE_W-1:0] SINE_SAMPLE_OUT,
  output logic SAMPLE_VALID_STROBE,
  output logic CARRY_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Buffer clock domain.

  // Tuning word buffer, written only on the buffer clock.
  logic [TW-1:0] buf_word_q;
  // Serial data shares the least significant parallel line.
  logic serial_tuning_pin;

  assign serial_tuning_pin = LINK.tune_word[0];

  // Load the buffer in parallel, or shift one bit in from the top so the
  // first bit sent ends in bit 0 and the last bit sent is the MSB.
  // The buffer is plain data and holds no reset; the host loads it first.
  always_ff @(posedge LINK.buffer_load_clock) begin
    if (LINK.buffer_load_enable) begin
      if (LINK.load_mode_parallel) begin
        buf_word_q <= LINK.tune_word;
      end else begin
        buf_word_q <= {serial_tuning_pin, buf_word_q[TW-1:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers into the system clock domain.

  // Bit order: transfer, clear, format, toggle, carry in.
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_q;  // First stage, read only by the second.
  logic [NSYNC-1:0] sync2_q;  // Second stage, safe for logic.
  logic xfer_s;
  logic clear_s;
  logic fmt_s;
  logic tgl_s;
  logic cin_s;

  assign pins_raw = {LINK.freq_word_transfer_strobe, PHASE_CLEAR, OUTPUT_FORMAT_SELECT,
                     CARRY_TOGGLE_ENABLE, ACCUMULATOR_CARRY_IN};

  // Two flip-flops per pin, cleared by reset so no strobe is seen early.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  assign xfer_s = sync2_q[4];
  assign clear_s = sync2_q[3];
  assign fmt_s = sync2_q[2];
  assign tgl_s = sync2_q[1];
  assign cin_s = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Frequency register.

  // Active increment of the accumulator.
  logic [TW-1:0] freq_q;

  // Copy the whole buffer on every edge that sees the synchronised strobe.
  // The host keeps the buffer clock still while the strobe is high, so the
  // multi-bit word is stable whenever it is sampled here.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      freq_q <= FREQ_RST;
    end else if (xfer_s) begin
      freq_q <= buf_word_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase accumulator.

  logic toggle_q;       // Internal alternating carry.
  logic carry_sel;      // Carry-in chosen for this cycle.
  logic [TW:0] acc_sum; // Sum with carry out on top.
  logic [TW-1:0] phase_q;
  logic carry_q;

  // Alternate between one and zero on every clock.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
    end
  end

  // The toggle replaces the external carry whenever it is enabled.
  assign carry_sel = tgl_s ? toggle_q : cin_s;

  // Increment is always the current frequency register, so a new word
  // takes effect the same way from any phase, cleared or not.
  assign acc_sum = {1'b0, phase_q} + {1'b0, freq_q} + {{TW{1'b0}}, carry_sel};

  // Advance the phase, or zero it while the clear is high.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_q <= PHASE_RST;
      carry_q <= 1'b0;
    end else if (clear_s) begin
      phase_q <= PHASE_RST;
      carry_q <= 1'b0;
    end else begin
      phase_q <= acc_sum[TW-1:0];
      carry_q <= acc_sum[TW];
    end
  end

  assign CARRY_OUT = carry_q;

  ////////////////////////////////////////////////////////////////////////////
  // Phase to sine, stage 1: fold the phase into the first quarter.

  logic [PHASE_IN_W-1:0] ph_top;
  logic [QTR_W:0] qtr_lo;   // Phase bits within the quarter, zero extended.
  logic [QTR_W:0] qtr_q;    // Phase within the quarter, up to a full quarter.
  logic half1_q;            // High for the negative half cycle.

  assign ph_top = phase_q[TW-1 -: PHASE_IN_W];
  assign qtr_lo = {1'b0, ph_top[QTR_W-1:0]};

  // Descending quarters read the table backwards.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      qtr_q <= '0;
      half1_q <= 1'b0;
    end else begin
      // Mirror about the quarter point, so a full quarter reaches the last entry.
      qtr_q <= ph_top[QTR_W] ? {1'b1, {QTR_W{1'b0}}} - qtr_lo : qtr_lo;
      half1_q <= ph_top[PHASE_IN_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: coarse table lookup.

  logic [TBL_IDX_W:0] idx;      // Table point below the phase, 0 to 64.
  logic [TBL_IDX_W:0] idx_nxt;  // Point above it, held at the last entry.
  logic [MAG_W-1:0] base_q;  // Table value below the phase.
  logic [MAG_W-1:0] step_q;  // Rise to the next table value.
  logic [FRAC_W-1:0] frac_q;
  logic half1_d2_q;

  assign idx = qtr_q[QTR_W -: TBL_IDX_W+1];
  // Only a full quarter sets the top bit, and then the fraction is zero.
  assign idx_nxt = idx[TBL_IDX_W] ? idx : idx + 7'd1;

  // Read the quarter-wave table once per clock.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      base_q <= '0;
      step_q <= '0;
      frac_q <= '0;
      half1_d2_q <= 1'b0;
    end else begin
      base_q <= QTR_TBL[idx][MAG_W-1:0];
      step_q <= QTR_TBL[idx_nxt][MAG_W-1:0] - QTR_TBL[idx][MAG_W-1:0];
      frac_q <= qtr_q[FRAC_W-1:0];
      half1_d2_q <= half1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 3: interpolate, apply the sign and the output format.

  // Linear interpolation between two neighbouring table points.
  function automatic logic [MAG_W-1:0] interp(input logic [MAG_W-1:0] b,
                                               input logic [MAG_W-1:0] s,
                                               input logic [FRAC_W-1:0] f);
    logic [MAG_W+FRAC_W-1:0] prod;
    prod = s * f;
    return b + prod[MAG_W+FRAC_W-1:FRAC_W];
  endfunction

  logic [MAG_W-1:0] mag;
  logic [SAMPLE_W-1:0] ubin;    // Offset-binary sample.
  logic [SAMPLE_W-1:0] fmt_out; // Sample in the selected format.
  logic [SAMPLE_W-1:0] sample_q;
  logic valid_q;

  assign mag = interp(base_q, step_q, frac_q);
  // Negative half sits below midscale, positive above.
  assign ubin = half1_d2_q ? SAMPLE_MID - {1'b0, mag} : SAMPLE_MID + {1'b0, mag};
  // Twos complement is offset binary with the top bit turned over.
  assign fmt_out = fmt_s ? {~ubin[SAMPLE_W-1], ubin[SAMPLE_W-2:0]} : ubin;

  // One output latch updates all twelve bits on the same edge.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sample_q <= SAMPLE_MID;
      valid_q <= 1'b0;
    end else begin
      sample_q <= fmt_out;
      valid_q <= 1'b1;
    end
  end

  assign SINE_SAMPLE_OUT = sample_q;

  // The strobe rises mid-cycle, while the latched sample is steady; its
  // duty follows the system clock, so it is unfit as a converter clock.
  assign SAMPLE_VALID_STROBE = valid_q & ~CLK;

endmodule

// ===== design/dds_host.sv
// Host end: command registers and the buffer-clock loader for the synthesizer.
`timescale 1ns/1ps
module dds_host
  import dds_pkg::*;
#(
  parameter int TW = TUNE_W,
  parameter int HALF_CYC = BCLK_HALF_CYC
) (
  // System clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Command port.
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Link toward the synthesizer.
  dds_link_if.host LINK
);

  ////////////////////////////////////////////////////////////////////////////
  // Command registers.

  logic [TW-1:0] tune_q;   // Word to send.
  logic par_q;             // Parallel load when set.
  logic done_q;            // Set when a load and transfer finish.
  logic go;                // Start pulse from the command register.
  dds_host_state_t state_q;
  logic finish;

  assign go = WR && (ADDR == REG_CMD) && WDATA[CMD_GO_BIT] && (state_q == DDS_IDLE);

  // Software writes; a start while busy is ignored.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tune_q <= '0;
      par_q <= 1'b0;
    end else if (WR && state_q == DDS_IDLE) begin
      if (ADDR == REG_TUNE) begin
        tune_q <= WDATA[TW-1:0];
      end else if (ADDR == REG_CTRL) begin
        par_q <= WDATA[CTRL_PAR_BIT];
      end
    end
  end

  // Done is cleared by a new start and set at the end of the transfer.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (go) begin
      done_q <= 1'b0;
    end
  end

  // Read data one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (RD) begin
      if (ADDR == REG_TUNE) begin
        RDATA <= tune_q;
      end else if (ADDR == REG_CTRL) begin
        RDATA <= {31'h0000_0000, par_q};
      end else if (ADDR == REG_STAT) begin
        RDATA <= {30'h0000_0000, done_q, state_q != DDS_IDLE};
      end else begin
        RDATA <= '0;
      end
    end else begin
      RDATA <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loader: divides CLK into the buffer clock and sends the word.

  logic [7:0] div_q;       // Position within one buffer clock period.
  logic [5:0] bits_q;      // Buffer clocks still to give.
  logic [TW-1:0] shreg_q;  // Serial word, bit 0 on the pin.
  logic period_end;

  assign period_end = (div_q == 8'(2 * HALF_CYC - 1));
  assign finish = (state_q == DDS_XFER) && (div_q == 8'(XFER_HOLD_CYC - 1));

  // Low half then high half; the rising edge comes mid-bit for setup.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= DDS_IDLE;
      div_q <= '0;
      bits_q <= '0;
      shreg_q <= '0;
    end else begin
      case (state_q)
        DDS_IDLE: begin
          div_q <= '0;
          if (go) begin
            state_q <= DDS_SHIFT;
            shreg_q <= tune_q;
            bits_q <= par_q ? 6'd1 : 6'(SERIAL_BITS);
          end
        end
        DDS_SHIFT: begin
          if (period_end) begin
            div_q <= '0;
            shreg_q <= {1'b0, shreg_q[TW-1:1]};
            bits_q <= bits_q - 6'd1;
            if (bits_q == 6'd1) begin
              state_q <= DDS_XFER;
            end
          end else begin
            div_q <= div_q + 8'd1;
          end
        end
        DDS_XFER: begin
          if (finish) begin
            state_q <= DDS_IDLE;
            div_q <= '0;
          end else begin
            div_q <= div_q + 8'd1;
          end
        end
        default: begin
          state_q <= DDS_IDLE;
        end
      endcase
    end
  end

  // Link outputs from flip-flops so the buffer clock is glitch free.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LINK.buffer_load_clock <= 1'b0;
      LINK.buffer_load_enable <= 1'b0;
      LINK.load_mode_parallel <= 1'b0;
      LINK.tune_word <= '0;
      LINK.freq_word_transfer_strobe <= 1'b0;
    end else begin
      // High for the second half of each period, the period end included.
      LINK.buffer_load_clock <= (state_q == DDS_SHIFT) && (div_q >= 8'(HALF_CYC));
      LINK.buffer_load_enable <= (state_q == DDS_SHIFT);
      LINK.load_mode_parallel <= par_q;
      // Serial sends bit 0 first and the MSB last on the shared pin.
      LINK.tune_word <= par_q ? tune_q : {{(TW-1){1'b0}}, shreg_q[0]};
      // Buffer clock is still here, so the word is stable for the copy.
      LINK.freq_word_transfer_strobe <= (state_q == DDS_XFER) && !finish;
    end
  end

endmodule

// ===== verif/dds_link_monitor.sv
// Checker of the host-to-synthesizer link and of the sample output.
`timescale 1ns/1ps
module dds_link_monitor
  import dds_pkg::*;
(
  // System clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Link signals.
  input wire logic buffer_load_clock,
  input wire logic buffer_load_enable,
  input wire logic load_mode_parallel,
  input wire logic [31:0] tune_word,
  input wire logic freq_word_transfer_strobe,
  // Synthesizer pins.
  input wire logic PHASE_CLEAR,
  input wire logic OUTPUT_FORMAT_SELECT,
  input wire logic [SAMPLE_W-1:0] SINE_SAMPLE_OUT,
  input wire logic SAMPLE_VALID_STROBE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////
  logic bclk_q; // Buffer clock one cycle ago.
  logic par_q; // Load mode seen at the last enabled buffer clock edge.
  logic [5:0] edges_q; // Enabled buffer clock edges in the current frame.

  // Counts enabled buffer clock edges; a transfer closes the frame.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bclk_q <= 1'b0;
      par_q <= 1'b0;
      edges_q <= 6'h00;
    end else begin
      bclk_q <= buffer_load_clock;
      if (buffer_load_clock && !bclk_q && buffer_load_enable) begin
        edges_q <= edges_q + 6'h01;
        par_q <= load_mode_parallel;
      end else if (freq_word_transfer_strobe) begin
        edges_q <= 6'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The transfer strobe is three cycles long.
  sequence strobe_burst;
    freq_word_transfer_strobe [*3] ##1 !freq_word_transfer_strobe;
  endsequence
  // The buffer clock stays high for two system clocks.
  sequence bclk_high;
    buffer_load_clock [*2] ##1 !buffer_load_clock;
  endsequence

  strobe_length_a: assert property ($rose(freq_word_transfer_strobe) |-> strobe_burst)
    else $error("transfer strobe length wrong");
  transfer_quiet_a: assert property (freq_word_transfer_strobe |-> !buffer_load_clock && !buffer_load_enable)
    else $error("buffer clock active during transfer");
  frame_count_a: assert property ($rose(freq_word_transfer_strobe) |-> (par_q ? edges_q == 6'h01 : edges_q == 6'h20))
    else $error("wrong buffer clock count before transfer");
  bclk_pulse_a: assert property ($rose(buffer_load_clock) |-> bclk_high)
    else $error("buffer clock high time wrong");
  bclk_framed_a: assert property (buffer_load_clock |-> buffer_load_enable)
    else $error("buffer clock outside load frame");
  data_setup_a: assert property (buffer_load_clock |-> $stable(tune_word) && $stable(load_mode_parallel))
    else $error("link data moved while buffer clock high");
  enable_lead_a: assert property ($rose(buffer_load_enable) |-> !buffer_load_clock ##1 !buffer_load_clock)
    else $error("enable without lead time");
  clear_mid_a: assert property (PHASE_CLEAR [*8] |=> SINE_SAMPLE_OUT == {~OUTPUT_FORMAT_SELECT, 11'h000})
    else $error("sample not midscale during phase clear");
  valid_edge_a: assert property ($past(RST_N) |-> SAMPLE_VALID_STROBE)
    else $error("valid strobe missing before clock edge");
endmodule

// ===== verif/dds_tuning_load_and_sine_output_test.sv
// Self-checking bench joining the host loader to the synthesizer.
`timescale 1ns/1ps
module dds_tuning_load_and_sine_output_test import dds_pkg::*;;
  logic clk; // System clock.
  logic rst_n; // Synchronous reset, active low.
  logic [3:0] addr; // Command port address.
  logic [31:0] wdata; // Command port write data.
  logic wr_stb; // Write strobe.
  logic rd_stb; // Read strobe.
  logic [31:0] rdata; // Read data.
  logic [31:0] rd_val; // Last value read.
  logic clr, fmt, carry_toggle_enable, accumulator_carry_in; // Synthesizer control pins.
  logic [11:0] sample; // Sample output.
  logic valid, carry; // Valid strobe and carry out.
  int n_fail, n_tests, cyc, zeros;

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  dds_link_if u_dds_link_if();
  dds_host u_dds_host (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
    .RDATA(rdata), .LINK(u_dds_link_if.host));
  dds_device u_dds_device (.CLK(clk), .RST_N(rst_n), .LINK(u_dds_link_if.device), .PHASE_CLEAR(clr),
    .OUTPUT_FORMAT_SELECT(fmt), .CARRY_TOGGLE_ENABLE(carry_toggle_enable), .ACCUMULATOR_CARRY_IN(accumulator_carry_in),
    .SINE_SAMPLE_OUT(sample), .SAMPLE_VALID_STROBE(valid), .CARRY_OUT(carry));
  dds_link_monitor u_dds_link_monitor (.CLK(clk), .RST_N(rst_n),
    .buffer_load_clock(u_dds_link_if.buffer_load_clock), .buffer_load_enable(u_dds_link_if.buffer_load_enable),
    .load_mode_parallel(u_dds_link_if.load_mode_parallel), .tune_word(u_dds_link_if.tune_word),
    .freq_word_transfer_strobe(u_dds_link_if.freq_word_transfer_strobe), .PHASE_CLEAR(clr),
    .OUTPUT_FORMAT_SELECT(fmt), .SINE_SAMPLE_OUT(sample), .SAMPLE_VALID_STROBE(valid));

  ////////////////////////////////////////////////////////////////////////////
  // Counts one comparison and reports a mismatch.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write on the command port.
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // One-cycle read; the data stand only in the following cycle.
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Starts a load, polls busy under a bound, then lets the copy and pipeline settle.
  task automatic load(input logic [31:0] w, input logic par);
    logic [31:0] st;
    int i;
    st = 32'h0000_0001;
    i = 0;
    bus_wr(REG_TUNE, w);
    bus_wr(REG_CTRL, {31'h0, par});
    bus_wr(REG_CMD, 32'h0000_0001);
    bus_wr(REG_TUNE, ~w);
    while (st[STAT_BUSY_BIT] !== 1'b0 && i < 100) begin
      bus_rd(REG_STAT, st);
      i++;
    end
    check("load status", st, 32'h0000_0002);
    bus_rd(REG_TUNE, rd_val);
    check("word kept while busy", rd_val, w);
    repeat (12) @(posedge clk);
  endtask

  // Waits for the first sample of a pattern, then expects the next three in consecutive cycles.
  task automatic seq4(input string what, input logic [47:0] exp);
    int i;
    i = 0;
    @(negedge clk);
    while (sample !== exp[47:36] && i < 64) begin
      @(negedge clk);
      i++;
    end
    check(what, {20'h0, sample}, {20'h0, exp[47:36]});
    for (int k = 2; k >= 0; k--) begin
      @(negedge clk);
      check(what, {20'h0, sample}, {20'h0, exp[k*12 +: 12]});
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    {clr, fmt, carry_toggle_enable, accumulator_carry_in} = 4'h0;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("reset sample", {20'h0, sample}, 32'h0000_0800);
    bus_rd(REG_STAT, rd_val);
    check("reset status", rd_val, 32'h0000_0000);
    $display("test reset done");
    // Quarter-cycle step loaded in parallel, both output formats.
    load(32'h4000_0000, 1'b1);
    seq4("quarter step", {12'hFFF, 12'h800, 12'h001, 12'h800});
    @(posedge clk) fmt <= 1'b1;
    seq4("twos complement", {12'h7FF, 12'h000, 12'h801, 12'h000});
    @(posedge clk) fmt <= 1'b0;
    $display("test parallel load done");
    // Eighth-cycle step shifted in serially while the phase runs.
    load(32'h2000_0000, 1'b0);
    seq4("serial step", {12'hFFF, 12'hDA7, 12'h800, 12'h259});
    $display("test serial load done");
    // Phase clear holds midscale, then the ramp restarts.
    @(posedge clk) clr <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("cleared sample", {20'h0, sample}, 32'h0000_0800);
    @(posedge clk) clr <= 1'b0;
    seq4("after clear", {12'hDA7, 12'hFFF, 12'hDA7, 12'h800});
    $display("test phase clear done");
    // Full-scale word with carry pin high always carries.
    load(32'hFFFF_FFFF, 1'b1);
    @(posedge clk) accumulator_carry_in <= 1'b1;
    repeat (8) @(posedge clk);
    zeros = 0;
    repeat (8) begin
      @(negedge clk);
      zeros += (carry === 1'b1) ? 0 : 1;
    end
    check("carry with pin", zeros, 32'h0000_0000);
    // Toggled carry ignores the pin and lets a zero-carry step through after a clear.
    @(posedge clk) carry_toggle_enable <= 1'b1;
    @(posedge clk) clr <= 1'b1;
    repeat (6) @(posedge clk);
    clr <= 1'b0;
    zeros = 0;
    repeat (12) begin
      @(negedge clk);
      zeros += (carry === 1'b0) ? 1 : 0;
    end
    // Three zeros while the clear drains, one more from the toggled carry at phase zero.
    check("toggled carry", zeros, 32'h0000_0004);
    $display("test carry done");
    tally_and_finish();
  end
endmodule
